// >>> src/adc_channel_sequencer_regs.v
// Channel sequencer: control registers, status, channel pointer, serial port
`timescale 1ns/1ps
`include "adc_seq_regs.vh"
module adc_channel_sequencer_regs (
    input  wire       clk_i,
    input  wire       srst_i,
    input  wire       clk_en_i,
    input  wire       spi_ce_i,
    input  wire       sck_i,
    input  wire       mosi_i,
    output wire       miso_o,
    output wire       miso_oe_o,
    input  wire       conv_done_i,
    input  wire [7:0] data_i,
    output reg        conv_start_o,
    output reg        conv_abort_o,
    output reg        conv_8bit_o,
    output reg  [2:0] mux_sel_o,
    output reg        byte_half_o,
    output reg  [7:0] chan_enable_o,
    output reg        data_rd_o,
    output reg  [3:0] data_addr_o,
    output reg        int_n_o
);
    ////////////////////////////////////////////////////////////////////
    // Control and status state
    reg  [7:0] mask_r;        // Channel enable mask
    reg  [7:0] mode_r;        // Mode select and resolution
    reg        go_r;          // Conversion go bit as written
    reg        load_r;        // Start address load bit as written
    reg  [2:0] ptr_r;         // Channel pointer
    reg        half_r;        // Byte-half of pointer
    reg        int_r;         // Interrupt flag
    reg        done_r;        // All-done flag
    reg        active_r;      // Conversion active flag
    reg        inhibit_r;     // No further conversions
    reg  [7:0] seen_r;        // Channels converted this frame
    reg        da_seen_r;     // Data access since start
    // Serial transaction state
    reg        cmd_r;         // Next byte is a command
    reg        wr_r;          // Transaction writes
    reg  [5:0] addr_r;        // Current register address
    reg        load_pend_r;   // Read byte to present
    reg        stat_pend_r;   // Status byte on the wire
    reg        rd_pend_r;     // Data byte on the wire
    reg  [7:0] tx_byte_r;     // Byte handed to the shifter
    reg        tx_load_r;     // Load strobe to the shifter
    // Shifter results
    wire       rx_valid;      // Byte received
    wire [7:0] rx_byte;       // Received byte
    wire       ce_fall;       // Chip enable dropped
    wire       ce_lvl;        // Chip enable synced level
    // Derived values
    wire [1:0] mode_sel;      // Conversion mode
    wire       eight_bit;     // Single byte results
    wire [2:0] next_ptr;      // Next enabled after pointer
    wire [7:0] seen_nxt;      // Frame set after this result
    wire       frame_full;    // Every enabled channel converted
    wire       byte_end;      // A read byte has finished
    wire       adv_chan;      // Read moves to next channel
    wire [7:0] status_live;   // Status register contents
    reg  [7:0] rd_mux;        // Read data of addressed register

    assign mode_sel   = mode_r[`MODE_SEL_MSB:0];
    assign eight_bit  = mode_r[`MODE_8BIT_BIT];
    assign seen_nxt   = seen_r | (8'h01 << ptr_r);
    assign frame_full = (mask_r != 8'h00) &&
                        ((seen_nxt & mask_r) == mask_r);
    assign byte_end   = (rx_valid && !cmd_r && !wr_r) || ce_fall;
    assign adv_chan   = eight_bit || half_r;
    assign next_ptr   = next_enabled(ptr_r, mask_r);
    // Unused bits held at zero
    assign status_live = {int_r, done_r, active_r, 1'b0,
                          ptr_r, 1'b0};

    ////////////////////////////////////////////////////////////////////
    // Next enabled channel above the pointer, wrapping
    function [2:0] next_enabled;
        input [2:0] cur;
        input [7:0] en;
        reg   [2:0] cand;
        reg         found;
        integer     k;
        begin
            next_enabled = cur;
            found        = 1'b0;
            for (k = 1; k < 9; k = k + 1) begin
                cand = cur + k[2:0];
                if (!found && en[cand]) begin
                    next_enabled = cand;
                    found        = 1'b1;
                end
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Serial byte shifter
    spi_byte_port u_port (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .clk_en_i   (clk_en_i),
        .sck_i      (sck_i),
        .mosi_i     (mosi_i),
        .ce_i       (spi_ce_i),
        .tx_load_i  (tx_load_r),
        .tx_byte_i  (tx_byte_r),
        .rx_valid_o (rx_valid),
        .rx_byte_o  (rx_byte),
        .ce_fall_o  (ce_fall),
        .ce_o       (ce_lvl),
        .miso_o     (miso_o),
        .miso_oe_o  (miso_oe_o)
    );

    ////////////////////////////////////////////////////////////////////
    // Read data selection by address
    always @* begin
        if (addr_r[5:4] == 2'h0) begin
            rd_mux = data_i;
        end else if (addr_r == `ADDR_MODE) begin
            rd_mux = mode_r;
        end else if (addr_r == `ADDR_MASK) begin
            rd_mux = mask_r;
        end else if (addr_r == `ADDR_START) begin
            // Unused bits read zero
            rd_mux = {go_r, 2'b00, load_r, ptr_r, half_r};
        end else if (addr_r == `ADDR_STATUS) begin
            rd_mux = status_live;
        end else begin
            rd_mux = 8'h00; // Unmapped reads zero
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers, transactions and conversion sequencing; later wins
    always @(posedge clk_i) begin
        if (srst_i) begin
            mask_r        <= `RST_MASK;
            mode_r        <= `RST_MODE;
            go_r          <= 1'b0;
            load_r        <= 1'b0;
            ptr_r         <= 3'h0;
            half_r        <= 1'b0;
            int_r         <= 1'b0;
            done_r        <= 1'b0;
            active_r      <= 1'b0;
            inhibit_r     <= 1'b0;
            seen_r        <= 8'h00;
            da_seen_r     <= 1'b0;
            cmd_r         <= 1'b1;
            wr_r          <= 1'b0;
            addr_r        <= 6'h00;
            load_pend_r   <= 1'b0;
            stat_pend_r   <= 1'b0;
            rd_pend_r     <= 1'b0;
            tx_byte_r     <= `RST_BYTE;
            tx_load_r     <= 1'b0;
            conv_start_o  <= 1'b0;
            conv_abort_o  <= 1'b0;
            conv_8bit_o   <= 1'b0;
            mux_sel_o     <= 3'h0;
            byte_half_o   <= 1'b0;
            chan_enable_o <= `RST_MASK;
            data_rd_o     <= 1'b0;
            data_addr_o   <= 4'h0;
            int_n_o       <= 1'b1;
        end else if (clk_en_i) begin
            conv_start_o <= 1'b0;
            conv_abort_o <= 1'b0;
            data_rd_o    <= 1'b0;
            tx_load_r    <= 1'b0;
            // Chip enable high in command phase: tx_byte_r cleared, no load strobe to the shifter
            if (ce_lvl && cmd_r && !load_pend_r && rx_valid == 1'b0 &&
                !stat_pend_r && !rd_pend_r) begin
                tx_byte_r <= 8'h00;
            end
            // Finished read byte: apply held-back side effects
            if (byte_end) begin
                if (stat_pend_r) begin
                    int_r <= 1'b0;
                end
                if (rd_pend_r) begin
                    if (adv_chan) begin
                        ptr_r  <= next_ptr;
                        half_r <= 1'b0;
                        if (mode_sel == `MODE_SINGLE && !inhibit_r) begin
                            conv_start_o <= 1'b1;
                            active_r     <= 1'b1;
                        end
                    end else begin
                        half_r <= 1'b1;
                    end
                end
                stat_pend_r <= 1'b0;
                rd_pend_r   <= 1'b0;
            end
            if (ce_fall) begin
                cmd_r       <= 1'b1;
                load_pend_r <= 1'b0;
            end else if (rx_valid && cmd_r) begin
                // Command byte: direction and address
                cmd_r       <= 1'b0;
                wr_r        <= rx_byte[`CMD_WRITE_BIT];
                addr_r      <= rx_byte[5:0];
                load_pend_r <= ~rx_byte[`CMD_WRITE_BIT];
            end else if (rx_valid && wr_r) begin
                // Register write
                if (addr_r == `ADDR_MODE || addr_r == `ADDR_MASK) begin
                    if (addr_r == `ADDR_MODE) begin
                        mode_r <= rx_byte;
                    end else begin
                        mask_r <= rx_byte;
                    end
                    int_r        <= 1'b0;
                    done_r       <= 1'b0;
                    active_r     <= 1'b0;
                    conv_abort_o <= active_r;
                    seen_r       <= 8'h00;
                end else if (addr_r == `ADDR_START) begin
                    go_r   <= rx_byte[`START_GO_BIT];
                    load_r <= rx_byte[`START_LOAD_BIT];
                    if (rx_byte[`START_LOAD_BIT]) begin
                        // Pointer and half loaded once
                        ptr_r  <= rx_byte[`START_CA_MSB:`START_CA_LSB];
                        half_r <= rx_byte[`START_HALF_BIT];
                    end
                    if (rx_byte[`START_GO_BIT] ||
                        rx_byte[`START_LOAD_BIT]) begin
                        conv_abort_o <= active_r;
                        active_r     <= 1'b0;
                        inhibit_r    <= 1'b0;
                    end else begin
                        // Current conversion runs out
                        inhibit_r <= 1'b1;
                    end
                    if (rx_byte[`START_GO_BIT] &&
                        mode_r[`MODE_SEL_MSB:0] != `MODE_IDLE) begin
                        conv_start_o <= 1'b1;
                        active_r     <= 1'b1;
                        seen_r       <= 8'h00;
                        da_seen_r    <= 1'b0;
                    end
                end
                if (addr_r != `ADDR_STATUS) begin
                    addr_r <= addr_r + 6'h01;
                end
            end else if (rx_valid) begin
                // Read burst: status stays, data follows pointer
                if (addr_r == `ADDR_STATUS) begin
                    addr_r <= addr_r;
                end else if (addr_r[5:4] == 2'h0) begin
                    addr_r <= adv_chan ? {2'h0, next_ptr, 1'b0}
                                       : {2'h0, ptr_r, 1'b1};
                end else begin
                    addr_r <= addr_r + 6'h01;
                end
                load_pend_r <= 1'b1;
            end
            // Present a read byte; status is a frozen snapshot
            if (load_pend_r && !ce_fall && !rx_valid) begin
                load_pend_r <= 1'b0;
                tx_load_r   <= 1'b1;
                tx_byte_r   <= rd_mux;
                if (addr_r == `ADDR_STATUS) begin
                    stat_pend_r <= 1'b1;
                end else if (addr_r[5:4] == 2'h0) begin
                    // Data access loads pointer and aborts
                    ptr_r        <= addr_r[3:1];
                    half_r       <= addr_r[0];
                    conv_abort_o <= active_r;
                    active_r     <= 1'b0;
                    done_r       <= 1'b0;
                    da_seen_r    <= 1'b1;
                    rd_pend_r    <= 1'b1;
                    data_rd_o    <= 1'b1;
                end
            end
            // Conversion finished: flags set last so sets win
            if (conv_done_i && active_r) begin
                active_r <= 1'b0;
                ptr_r    <= next_ptr;
                half_r   <= 1'b0;
                seen_r   <= frame_full ? 8'h00 : seen_nxt;
                case (mode_sel)
                    `MODE_SINGLE: begin
                        int_r <= 1'b1;
                        if (frame_full && !da_seen_r) begin
                            done_r <= 1'b1;
                        end
                    end
                    `MODE_SCAN: begin
                        if (frame_full) begin
                            int_r  <= 1'b1;
                            done_r <= 1'b1;
                        end else if (!inhibit_r) begin
                            conv_start_o <= 1'b1;
                            active_r     <= 1'b1;
                        end
                    end
                    `MODE_CONT: begin
                        if (frame_full) begin
                            done_r <= 1'b1;
                        end
                        if (!inhibit_r) begin
                            conv_start_o <= 1'b1;
                            active_r     <= 1'b1;
                        end
                    end
                    default: begin
                        active_r <= 1'b0;
                    end
                endcase
            end
            // Output mirrors
            conv_8bit_o   <= eight_bit;
            mux_sel_o     <= ptr_r;
            byte_half_o   <= half_r;
            chan_enable_o <= mask_r;
            data_addr_o   <= addr_r[3:0];
            int_n_o       <= ~int_r;
        end
    end
endmodule

// >>> src/adc_seq_regs.vh
// Register map, field positions and reset values of the channel sequencer
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH

// Register addresses (six-bit address field of the command byte)
`define ADDR_MODE        6'h10
`define ADDR_MASK        6'h11
`define ADDR_START       6'h12
`define ADDR_STATUS      6'h13

// Command byte fields
`define CMD_WRITE_BIT    7

// Start register fields
`define START_GO_BIT     7
`define START_LOAD_BIT   4
`define START_CA_MSB     3
`define START_CA_LSB     1
`define START_HALF_BIT   0

// Status register fields
`define STAT_INT_BIT     7
`define STAT_DONE_BIT    6
`define STAT_ACTIVE_BIT  5

// Mode register fields
`define MODE_SEL_MSB     1
`define MODE_8BIT_BIT    2
`define MODE_IDLE        2'h0
`define MODE_SINGLE      2'h1
`define MODE_SCAN        2'h2
`define MODE_CONT        2'h3

// Reset values
`define RST_MASK         8'h00
`define RST_MODE         8'h00
`define RST_BYTE         8'h00

`endif

// >>> src/spi_byte_port.v
// Serial slave byte shifter: pin synchronisers, bit count, byte framing
`timescale 1ns/1ps
module spi_byte_port (
    input  wire       clk_i,
    input  wire       srst_i,
    input  wire       clk_en_i,
    input  wire       sck_i,
    input  wire       mosi_i,
    input  wire       ce_i,
    input  wire       tx_load_i,
    input  wire [7:0] tx_byte_i,
    output reg        rx_valid_o,
    output reg  [7:0] rx_byte_o,
    output reg        ce_fall_o,
    output reg        ce_o,
    output reg        miso_o,
    output reg        miso_oe_o
);
    ////////////////////////////////////////////////////////////////////
    reg  [2:0] sck_sync_r;   // Two sync stages plus edge history
    reg  [1:0] mosi_sync_r;  // Two sync stages
    reg  [1:0] ce_sync_r;    // Two sync stages
    reg  [2:0] bit_cnt_r;    // Rising edges within the byte
    reg  [6:0] rx_sh_r;      // Bits received so far
    reg  [6:0] tx_sh_r;      // Bits still to send
    wire       sck_rise;     // Clock rising, sample side
    wire       sck_fall;     // Clock falling, drive side

    assign sck_rise = sck_sync_r[1] & ~sck_sync_r[2];
    assign sck_fall = ~sck_sync_r[1] & sck_sync_r[2];

    ////////////////////////////////////////////////////////////////////
    // Synchronisers; first stage feeds only the second
    always @(posedge clk_i) begin
        if (srst_i) begin
            sck_sync_r  <= 3'h0;
            mosi_sync_r <= 2'h0;
            ce_sync_r   <= 2'h0;
        end else if (clk_en_i) begin
            sck_sync_r  <= {sck_sync_r[1:0], sck_i};
            mosi_sync_r <= {mosi_sync_r[0], mosi_i};
            ce_sync_r   <= {ce_sync_r[0], ce_i};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shift in on rising, out on falling; msb first both ways
    always @(posedge clk_i) begin
        if (srst_i) begin
            bit_cnt_r  <= 3'h0;
            rx_sh_r    <= 7'h00;
            tx_sh_r    <= 7'h00;
            rx_valid_o <= 1'b0;
            rx_byte_o  <= 8'h00;
            ce_fall_o  <= 1'b0;
            ce_o       <= 1'b0;
            miso_o     <= 1'b0;
            miso_oe_o  <= 1'b0;
        end else if (clk_en_i) begin
            rx_valid_o <= 1'b0;
            ce_o       <= ce_sync_r[1];
            ce_fall_o  <= ce_o & ~ce_sync_r[1];
            miso_oe_o  <= ce_sync_r[1];
            if (!ce_sync_r[1]) begin
                // Deselected: restart framing
                bit_cnt_r <= 3'h0;
            end else if (sck_rise) begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
                rx_sh_r   <= {rx_sh_r[5:0], mosi_sync_r[1]};
                if (bit_cnt_r == 3'h7) begin
                    rx_valid_o <= 1'b1;
                    rx_byte_o  <= {rx_sh_r, mosi_sync_r[1]};
                end
            end else if (sck_fall && bit_cnt_r != 3'h0) begin
                // Skip the falling edge that ends a byte
                miso_o  <= tx_sh_r[6];
                tx_sh_r <= {tx_sh_r[5:0], 1'b0};
            end
            if (tx_load_i) begin
                // New byte: msb out at once
                miso_o  <= tx_byte_i[7];
                tx_sh_r <= tx_byte_i[6:0];
            end
        end
    end
endmodule

// >>> sim/adc_seq_monitor.sv
// Port assertions of the channel sequencer
`timescale 1ns/1ps
module adc_seq_monitor (
    input wire       clk_i,
    input wire       srst_i,
    input wire       clk_en_i,
    input wire       spi_ce_i,
    input wire       conv_done_i,
    input wire       miso_oe_o,
    input wire       conv_start_o,
    input wire       conv_abort_o,
    input wire [2:0] mux_sel_o,
    input wire [7:0] chan_enable_o,
    input wire       int_n_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    logic [3:0] ce_age_r; // Cycles since chip enable was last high
    // Age of the last serial frame, saturating
    always @(posedge clk_i) begin
        if (srst_i || spi_ce_i)
            ce_age_r <= srst_i ? 4'hf : 4'h0;
        else if (ce_age_r != 4'hf)
            ce_age_r <= ce_age_r + 4'h1;
    end
    reset_int_a: assert property (disable iff (1'b0)
        srst_i && clk_en_i |=> int_n_o) else $error("int low after reset");
    start_pulse_a: assert property (
        conv_start_o |=> !conv_start_o) else $error("start too long");
    start_cause_a: assert property (
        conv_start_o |-> ce_age_r < 4'hc || $past(conv_done_i) ||
        $past(conv_done_i, 2) || $past(conv_done_i, 3))
        else $error("start without cause");
    abort_cause_a: assert property (
        conv_abort_o |-> ce_age_r < 4'hc) else $error("abort without access");
    mask_hold_a: assert property (
        $changed(chan_enable_o) |-> $past(spi_ce_i, 3))
        else $error("mask changed without write");
    ptr_move_a: assert property (
        $changed(mux_sel_o) |-> ce_age_r < 4'hc || $past(conv_done_i) ||
        $past(conv_done_i, 2) || $past(conv_done_i, 3))
        else $error("pointer moved without cause");
    int_set_a: assert property (
        $fell(int_n_o) |-> $past(conv_done_i) || $past(conv_done_i, 2) ||
        $past(conv_done_i, 3)) else $error("int without conversion");
    oe_off_a: assert property (
        (!spi_ce_i)[*4] |-> !miso_oe_o) else $error("drives while idle");
endmodule
bind adc_channel_sequencer_regs adc_seq_monitor adc_seq_monitor_inst (
    .clk_i(clk_i), .srst_i(srst_i), .clk_en_i(clk_en_i),
    .spi_ce_i(spi_ce_i), .conv_done_i(conv_done_i),
    .miso_oe_o(miso_oe_o), .conv_start_o(conv_start_o),
    .conv_abort_o(conv_abort_o), .mux_sel_o(mux_sel_o),
    .chan_enable_o(chan_enable_o), .int_n_o(int_n_o));

// >>> sim/spi_host_model.sv
// Serial host model: mode 0 master with chip enable
`timescale 1ns/1ps
module spi_host_model (
    input  wire  clk_i,
    input  wire  miso_i,
    output logic sck_o,
    output logic mosi_o,
    output logic ce_o
);
    // Clock idles low, chip enable off from time zero
    initial begin
        sck_o = 1'b0;
        mosi_o = 1'b0;
        ce_o = 1'b0;
    end
    // Whole system clock cycles
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Select, then let the enable cross the synchroniser
    task automatic open_frame;
        ce_o <= 1'b1;
        tick(10);
    endtask
    // One byte each way, msb first, phases of ten cycles
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi_o <= tx[i];
            tick(10);
            sck_o <= 1'b1;
            rx[i] = miso_i;
            tick(10);
            sck_o <= 1'b0;
        end
    endtask
    // Deselect; released data line shows no stale bit
    task automatic close_frame;
        tick(10);
        ce_o <= 1'b0;
        mosi_o <= ~mosi_o;
        tick(20);
    endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench of the channel sequencer registers
`timescale 1ns/1ps
`include "adc_seq_regs.vh"
module tb;
    logic       clk_i = 1'b0;       // 25 MHz clock
    logic       srst_i = 1'b1;      // Synchronous reset
    logic       clk_en_i = 1'b1;    // Always running
    logic       conv_done_i = 1'b0; // Core completion pulse
    logic [7:0] data_i = 8'h5a;     // Data store byte
    wire        spi_ce_i, sck_i, mosi_i, miso_o;
    wire        conv_start_o, conv_abort_o, byte_half_o, int_n_o;
    wire  [2:0] mux_sel_o;
    wire  [7:0] chan_enable_o;
    wire        conv_8bit_o;        // Eight-bit mode level
    logic [7:0] rx;                 // Last byte from the device
    int         busy_cnt = 0, n_starts = 0, n_aborts = 0;
    int         mismatches = 0, samples_checked = 0;
    always #20 clk_i = ~clk_i;
    adc_channel_sequencer_regs adc_channel_sequencer_regs_inst (
        .clk_i(clk_i), .srst_i(srst_i), .clk_en_i(clk_en_i),
        .spi_ce_i(spi_ce_i), .sck_i(sck_i), .mosi_i(mosi_i),
        .miso_o(miso_o), .miso_oe_o(), .conv_done_i(conv_done_i),
        .data_i(data_i), .conv_start_o(conv_start_o),
        .conv_abort_o(conv_abort_o), .conv_8bit_o(conv_8bit_o),
        .mux_sel_o(mux_sel_o),
        .byte_half_o(byte_half_o), .chan_enable_o(chan_enable_o),
        .data_rd_o(), .data_addr_o(), .int_n_o(int_n_o));
    spi_host_model spi_host_model_inst (.clk_i(clk_i), .miso_i(miso_o),
        .sck_o(sck_i), .mosi_o(mosi_i), .ce_o(spi_ce_i));
    // Conversion core stand-in: a start finishes 30 cycles later unless aborted
    always @(posedge clk_i) begin
        conv_done_i <= 1'b0;
        if (conv_start_o === 1'b1) begin
            busy_cnt <= 30;
            n_starts <= n_starts + 1;
        end else if (conv_abort_o === 1'b1) begin
            busy_cnt <= 0;
            n_aborts <= n_aborts + 1;
        end else if (busy_cnt == 1) begin
            busy_cnt <= 0;
            conv_done_i <= 1'b1;
        end else if (busy_cnt != 0) begin
            busy_cnt <= busy_cnt - 1;
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Single register write frame
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        spi_host_model_inst.open_frame();
        spi_host_model_inst.xfer({2'b10, a}, rx);
        spi_host_model_inst.xfer(d, rx);
        spi_host_model_inst.close_frame();
    endtask
    // Read burst of n bytes, each masked and compared
    task automatic rd(input logic [5:0] a, input int n,
                      input logic [7:0] exp, input logic [7:0] msk);
        spi_host_model_inst.open_frame();
        spi_host_model_inst.xfer({2'b00, a}, rx);
        repeat (n) begin
            spi_host_model_inst.xfer(8'h00, rx);
            check(rx & msk, exp);
        end
        spi_host_model_inst.close_frame();
    endtask
    // Burst of mode, mask of channels 0 and 2, then start
    task automatic run(input logic [7:0] m, input logic [7:0] s);
        spi_host_model_inst.open_frame();
        spi_host_model_inst.xfer({2'b10, `ADDR_MODE}, rx);
        spi_host_model_inst.xfer(m, rx);
        spi_host_model_inst.xfer(8'h05, rx);
        spi_host_model_inst.xfer(s, rx);
        spi_host_model_inst.close_frame();
    endtask
    // Bounded wait for the start count
    task automatic wait_starts(input int k);
        int i;
        for (i = 0; i < 3000 && n_starts < k; i++) @(posedge clk_i);
        if (i == 3000) begin
            mismatches++;
            final_report();
        end
    endtask
    task automatic t_reset;
        check({7'h00, int_n_o}, 8'h01);
        rd(`ADDR_MASK, 1, 8'h00, 8'hff);
        rd(`ADDR_STATUS, 1, 8'h00, 8'hff);
        rd(6'h3f, 1, 8'h00, 8'hff);
        $display("reset test done");
    endtask
    task automatic t_mask;
        wr(`ADDR_MASK, 8'ha5);
        rd(`ADDR_MASK, 1, 8'ha5, 8'hff);
        check(chan_enable_o, 8'ha5);
        $display("mask test done");
    endtask
    task automatic t_load;
        int b;
        b = n_starts;
        wr(`ADDR_START, 8'h7e);
        rd(`ADDR_START, 1, 8'h1e, 8'hff);
        check({5'h00, mux_sel_o}, 8'h07);
        check({7'h00, byte_half_o}, 8'h00);
        rd(`ADDR_STATUS, 2, 8'h0e, 8'hff);
        check({5'h00, mux_sel_o}, 8'h07);
        check(8'(n_starts - b), 8'h00);
        $display("load test done");
    endtask
    task automatic t_scan;
        int b;
        b = n_starts;
        run(8'h02, 8'h90);
        wait_starts(b + 2);
        repeat (40) @(posedge clk_i);
        check(8'(n_starts - b), 8'h02);
        check({5'h00, mux_sel_o}, 8'h00);
        check({7'h00, int_n_o}, 8'h00);
        rd(`ADDR_STATUS, 1, 8'hc0, 8'hff);
        check({7'h00, int_n_o}, 8'h01);
        rd(`ADDR_STATUS, 1, 8'h40, 8'hff);
        rd(6'h00, 1, 8'h5a, 8'hff);
        rd(`ADDR_STATUS, 1, 8'h00, 8'h40);
        $display("scan test done");
    endtask
    task automatic t_stop;
        int b, s;
        b = n_starts;
        run(8'h03, 8'h90);
        wait_starts(b + 3);
        b = n_aborts;
        wr(`ADDR_START, 8'h00);
        repeat (100) @(posedge clk_i);
        s = n_starts;
        repeat (100) @(posedge clk_i);
        check(8'(n_starts - s), 8'h00);
        check(8'(n_aborts - b), 8'h00);
        rd(`ADDR_STATUS, 1, 8'h40, 8'he0);
        $display("stop test done");
    endtask
    task automatic t_abort;
        int b;
        b = n_starts;
        run(8'h03, 8'h90);
        wait_starts(b + 1);
        b = n_aborts;
        wr(`ADDR_MASK, 8'h05);
        check(8'(n_aborts - b), 8'h01);
        rd(`ADDR_STATUS, 1, 8'h00, 8'h20);
        $display("abort test done");
    endtask
    task automatic t_single;
        int b;
        b = n_starts;
        run(8'h05, 8'h90);
        wait_starts(b + 1);
        repeat (40) @(posedge clk_i);
        check({7'h00, conv_8bit_o}, 8'h01);
        check({7'h00, int_n_o}, 8'h00);
        rd(`ADDR_STATUS, 1, 8'h84, 8'hff);
        check(8'(n_starts - b), 8'h01);
        $display("single test done");
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_mask();
        t_load();
        t_scan();
        t_stop();
        t_abort();
        t_single();
        final_report();
    end
endmodule
